// *** qp_pwm_top.sv ***
// Four 24-bit modulators with port C line takeover, behind an AXI4-Lite slave.
// Assumes one clock, synchronous reset, and port C pins that come from outside.
//
// How it works
// R1 - Four independent channels are built, each with 24-bit counters.
// R2 - A channel makes a square wave up to 25 MHz, duty 0% to 100%, extremes constant.
// R3 - Each channel has a polarity bit choosing whether the active part is high or low.
// R4 - Each channel has a period counter and a duty counter loaded from software values.
// R5 - On start both counters count down from the same cycle and the output goes active.
// R6 - A duty counter at zero holds there and the output is inactive for the rest.
// R7 - A period counter at zero reloads both counters and the output goes active again.
// R8 - Software may change the duty value while the channel keeps running.
// R9 - A running, enabled channel drives its I/O line and forces it to output.
// R10 - Channels 0 to 3 drive port C bits 4 to 7 in ascending order.
// R11 - Every port C line has its own direction bit.
// R12 - After reset every port C line is an input.
// R13 - A stopped or disabled channel gives the line back to its software settings.
// R14 - A new duty value takes effect at the next period reload, never mid-pulse.
//
// Implementation choices: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps

module qp_pwm_top #(
  parameter int NUM_CH = qp_pkg::NUM_CH,
  parameter int CNT_W = qp_pkg::CNT_W,
  parameter int PORT_W = qp_pkg::PORT_W
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [PORT_W-1:0] port_c_lines_i,
  output logic [PORT_W-1:0] port_c_lines_o,
  output logic [PORT_W-1:0] port_c_lines_oe
);

  typedef logic [qp_pkg::CTRL_W-1:0] qp_ctrl_t;

  // Byte-lane merge for narrow and wide registers alike
  function automatic logic [31:0] qp_merge(
    input logic [31:0] old_v,
    input logic [31:0] new_v,
    input logic [3:0] strb
  );
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // Write channel capture
  logic aw_full_q;
  logic w_full_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic wr_en;
  logic wr_hit;

  // Read channel
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic [31:0] rd_val;
  logic rd_hit;

  // Software state
  logic [qp_pkg::CTRL_W-1:0] ctrl_q;
  logic [PORT_W-1:0] dir_q;
  logic [PORT_W-1:0] out_q;
  logic [CNT_W-1:0] period_q [NUM_CH];
  logic [CNT_W-1:0] duty_q [NUM_CH];

  // Channel state
  logic [NUM_CH-1:0] running_q;
  logic [NUM_CH-1:0] level;
  logic [NUM_CH-1:0] take;
  logic [CNT_W-1:0] pcnt_q [NUM_CH];
  logic [CNT_W-1:0] dcnt_q [NUM_CH];

  // Pin side
  logic [PORT_W-1:0] pin_meta_q;
  logic [PORT_W-1:0] pin_sync_q;
  logic [PORT_W-1:0] pin_o_q;
  logic [PORT_W-1:0] pin_oe_q;

  assign s_axi_awready = ~aw_full_q;
  assign s_axi_wready = ~w_full_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = ~rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign port_c_lines_o = pin_o_q;
  assign port_c_lines_oe = pin_oe_q;

  // Write takes place once both address and data are held and no answer is pending
  assign wr_en = aw_full_q & w_full_q & ~bvalid_q;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      aw_full_q <= 1'b0;
      awaddr_q <= 8'h00;
    end else if (s_axi_awvalid && !aw_full_q) begin
      aw_full_q <= 1'b1;
      awaddr_q <= s_axi_awaddr;
    end else if (wr_en) begin
      aw_full_q <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      w_full_q <= 1'b0;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
    end else if (s_axi_wvalid && !w_full_q) begin
      w_full_q <= 1'b1;
      wdata_q <= s_axi_wdata;
      wstrb_q <= s_axi_wstrb;
    end else if (wr_en) begin
      w_full_q <= 1'b0;
    end
  end

  // Write decode: only the word-aligned offsets below are mapped
  always_comb begin
    wr_hit = 1'b0;
    if (awaddr_q[1:0] == 2'b00) begin
      if (awaddr_q == qp_pkg::CTRL_OFS || awaddr_q == qp_pkg::DIR_OFS ||
          awaddr_q == qp_pkg::OUT_OFS) begin
        wr_hit = 1'b1;
      end
      for (int c = 0; c < NUM_CH; c++) begin
        if (awaddr_q == 8'(qp_pkg::CH_BASE + c * qp_pkg::CH_STRIDE) ||
            awaddr_q == 8'(qp_pkg::CH_BASE + c * qp_pkg::CH_STRIDE + qp_pkg::DUTY_SUB)) begin
          wr_hit = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      bvalid_q <= 1'b0;
      bresp_q <= qp_pkg::RESP_OKAY;
    end else if (wr_en) begin
      bvalid_q <= 1'b1;
      bresp_q <= wr_hit ? qp_pkg::RESP_OKAY : qp_pkg::RESP_DECERR;
    end else if (bvalid_q && s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      ctrl_q <= qp_pkg::CTRL_RST;
    end else if (wr_en && awaddr_q == qp_pkg::CTRL_OFS) begin
      ctrl_q <= qp_ctrl_t'(qp_merge(32'(ctrl_q), wdata_q, wstrb_q));
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      dir_q <= qp_pkg::DIR_RST; // see R12
    end else if (wr_en && awaddr_q == qp_pkg::DIR_OFS) begin
      dir_q <= PORT_W'(qp_merge(32'(dir_q), wdata_q, wstrb_q)); // see R11
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      out_q <= qp_pkg::OUT_RST;
    end else if (wr_en && awaddr_q == qp_pkg::OUT_OFS) begin
      out_q <= PORT_W'(qp_merge(32'(out_q), wdata_q, wstrb_q));
    end
  end

  // Pins come from outside, so two flops before anything reads them
  always_ff @(posedge core_clk) begin
    if (reset) begin
      pin_meta_q <= '0;
      pin_sync_q <= '0;
    end else begin
      pin_meta_q <= port_c_lines_i;
      pin_sync_q <= pin_meta_q;
    end
  end

  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : gen_ch // see R1
      localparam logic [7:0] PER_A = 8'(qp_pkg::CH_BASE + g * qp_pkg::CH_STRIDE);
      localparam logic [7:0] DUT_A = 8'(PER_A + qp_pkg::DUTY_SUB);
      logic run_bit;
      logic [CNT_W-1:0] per_load;

      assign run_bit = ctrl_q[qp_pkg::RUN_LSB + g];
      // Periods shorter than the floor would exceed the top output rate
      assign per_load = (period_q[g] < CNT_W'(qp_pkg::MIN_PERIOD_CYC - 1)) ?
                        CNT_W'(qp_pkg::MIN_PERIOD_CYC - 1) : period_q[g]; // see R2

      always_ff @(posedge core_clk) begin
        if (reset) begin
          period_q[g] <= CNT_W'(qp_pkg::PERIOD_RST);
        end else if (wr_en && awaddr_q == PER_A) begin
          period_q[g] <= CNT_W'(qp_merge(32'(period_q[g]), wdata_q, wstrb_q)); // see R4
        end
      end

      // Duty may be rewritten at any time; counters pick it up only on start or reload
      always_ff @(posedge core_clk) begin
        if (reset) begin
          duty_q[g] <= CNT_W'(qp_pkg::DUTY_RST);
        end else if (wr_en && awaddr_q == DUT_A) begin
          duty_q[g] <= CNT_W'(qp_merge(32'(duty_q[g]), wdata_q, wstrb_q)); // see R8
        end
      end

      always_ff @(posedge core_clk) begin
        if (reset) begin
          running_q[g] <= 1'b0;
          pcnt_q[g] <= '0;
          dcnt_q[g] <= '0;
        end else if (!run_bit) begin
          running_q[g] <= 1'b0;
          dcnt_q[g] <= '0;
        end else if (!running_q[g]) begin
          running_q[g] <= 1'b1;
          pcnt_q[g] <= per_load; // see R5
          dcnt_q[g] <= duty_q[g]; // see R5
        end else if (pcnt_q[g] == '0) begin
          pcnt_q[g] <= per_load; // see R7
          dcnt_q[g] <= duty_q[g]; // see R14
        end else begin
          pcnt_q[g] <= pcnt_q[g] - 1'b1;
          if (dcnt_q[g] != '0) begin
            dcnt_q[g] <= dcnt_q[g] - 1'b1;
          end // see R6
        end
      end

      // Active while duty remains; polarity bit 1 means active high
      assign level[g] = running_q[g] &
        ((dcnt_q[g] != '0) ~^ ctrl_q[qp_pkg::POL_LSB + g]); // see R3
      assign take[g] = running_q[g] & ctrl_q[qp_pkg::OEN_LSB + g]; // see R9
    end
  endgenerate

  // Per-line mux between software settings and a channel taking the line
  always_ff @(posedge core_clk) begin
    if (reset) begin
      pin_o_q <= '0;
      pin_oe_q <= '0; // see R12
    end else begin
      for (int b = 0; b < PORT_W; b++) begin
        pin_o_q[b] <= out_q[b];
        pin_oe_q[b] <= dir_q[b]; // see R13
      end
      // Looping over channels keeps every line index in range
      for (int c = 0; c < NUM_CH; c++) begin
        if (take[c]) begin // see R10
          pin_o_q[qp_pkg::PIN_BASE + c] <= level[c];
          pin_oe_q[qp_pkg::PIN_BASE + c] <= 1'b1; // see R9
        end
      end
    end
  end

  // Read decode
  always_comb begin
    rd_val = 32'h0000_0000;
    rd_hit = 1'b0;
    if (s_axi_araddr[1:0] == 2'b00) begin
      case (s_axi_araddr)
        qp_pkg::CTRL_OFS: begin
          rd_val = 32'(ctrl_q);
          rd_hit = 1'b1;
        end
        qp_pkg::DIR_OFS: begin
          rd_val = 32'(dir_q);
          rd_hit = 1'b1;
        end
        qp_pkg::OUT_OFS: begin
          rd_val = 32'(out_q);
          rd_hit = 1'b1;
        end
        qp_pkg::IN_OFS: begin
          rd_val = 32'(pin_sync_q);
          rd_hit = 1'b1;
        end
        qp_pkg::STAT_OFS: begin
          rd_val = 32'({level, running_q});
          rd_hit = 1'b1;
        end
        default: begin
          rd_val = 32'h0000_0000;
        end
      endcase
      for (int c = 0; c < NUM_CH; c++) begin
        if (s_axi_araddr == 8'(qp_pkg::CH_BASE + c * qp_pkg::CH_STRIDE)) begin
          rd_val = 32'(period_q[c]);
          rd_hit = 1'b1;
        end
        if (s_axi_araddr ==
            8'(qp_pkg::CH_BASE + c * qp_pkg::CH_STRIDE + qp_pkg::DUTY_SUB)) begin
          rd_val = 32'(duty_q[c]);
          rd_hit = 1'b1;
        end
        if (s_axi_araddr == 8'(qp_pkg::CNT_BASE + c * qp_pkg::CNT_STRIDE)) begin
          rd_val = 32'(pcnt_q[c]);
          rd_hit = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= qp_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && !rvalid_q) begin
      rvalid_q <= 1'b1;
      rdata_q <= rd_val;
      rresp_q <= rd_hit ? qp_pkg::RESP_OKAY : qp_pkg::RESP_DECERR;
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

endmodule // qp_pwm_top

// *** qp_pkg.sv ***
// Constants for the four-channel modulator block with port C takeover.
// Assumes a single 100 MHz clock and an AXI4-Lite master on the register side.
package qp_pkg;

  // Geometry
  localparam int NUM_CH = 4;
  localparam int CNT_W = 24;
  localparam int PORT_W = 8;
  localparam int PIN_BASE = 4;

  // Timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int MAX_FREQ_MHZ = 25;
  localparam int MIN_PERIOD_CYC = (1000 + MAX_FREQ_MHZ * CLK_PERIOD_NS - 1)
                                  / (MAX_FREQ_MHZ * CLK_PERIOD_NS);

  // Register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] DIR_OFS = 8'h04;
  localparam logic [7:0] OUT_OFS = 8'h08;
  localparam logic [7:0] IN_OFS = 8'h0c;
  localparam logic [7:0] STAT_OFS = 8'h10;
  localparam logic [7:0] CH_BASE = 8'h20;
  localparam logic [7:0] CH_STRIDE = 8'h08;
  localparam logic [7:0] DUTY_SUB = 8'h04;
  localparam logic [7:0] CNT_BASE = 8'h40;
  localparam logic [7:0] CNT_STRIDE = 8'h04;

  // Control field positions
  localparam int RUN_LSB = 0;
  localparam int OEN_LSB = 4;
  localparam int POL_LSB = 8;
  localparam int CTRL_W = 12;

  // Reset values
  localparam logic [CTRL_W-1:0] CTRL_RST = 12'h000;
  localparam logic [7:0] DIR_RST = 8'h00;
  localparam logic [7:0] OUT_RST = 8'h00;
  localparam logic [23:0] PERIOD_RST = 24'h000003;
  localparam logic [23:0] DUTY_RST = 24'h000000;

  // Bus answers
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_DECERR = 2'b11;

endpackage

// *** qp_pwm_sva.sv ***
// Checker for the modulator block's bus handshakes and pin reset state.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/1ps
module qp_pwm_sva (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [7:0] port_c_lines_oe
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
  a_b_hold: assert property (p_b_hold) else $error("bvalid dropped early");
  property p_b_drop; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
  a_b_drop: assert property (p_b_drop) else $error("bvalid stayed after bready");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read answer not held");
  property p_r_drop; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid; endproperty
  a_r_drop: assert property (p_r_drop) else $error("rvalid stayed after rready");
  property p_ar_ans; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_ar_ans: assert property (p_ar_ans) else $error("read answer late");
  property p_ar_blk; s_axi_rvalid |-> !s_axi_arready; endproperty
  a_ar_blk: assert property (p_ar_blk) else $error("arready while rvalid");
  property p_w_ans;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:3] s_axi_bvalid;
  endproperty
  a_w_ans: assert property (p_w_ans) else $error("write answer late");
  property p_aw_blk; s_axi_awvalid && s_axi_awready |=> !s_axi_awready; endproperty
  a_aw_blk: assert property (p_aw_blk) else $error("awready while write held");
  property p_resp; s_axi_bvalid |-> s_axi_bresp inside {2'h0, 2'h3}; endproperty
  a_resp: assert property (p_resp) else $error("bad write response code");
  property p_oe_rst; $fell(reset) |-> port_c_lines_oe == 8'h00; endproperty
  a_oe_rst: assert property (p_oe_rst) else $error("pin driven after reset");
  c_wr: cover property (s_axi_bvalid && s_axi_bready);
  c_rd: cover property (s_axi_rvalid && s_axi_rready);
  c_take: cover property (port_c_lines_oe[7:4] != 4'h0);
endmodule // qp_pwm_sva

// *** qp_load.sv ***
// External load on the port C lines.
// Assumes undriven lines settle to the level the load itself applies.
`timescale 1ns/1ps
module qp_load (
  input wire logic [7:0] lines_o,
  input wire logic [7:0] lines_oe,
  input wire logic [7:0] ext_val,
  output logic [7:0] lines_i
);
  // Wire level: the block wins where it drives, otherwise the load
  assign lines_i = (lines_oe & lines_o) | (~lines_oe & ext_val);
endmodule // qp_load

// *** test_quad_pwm_with_pin_takeover.sv ***
// Self-checking bench for the four-channel modulator with port C takeover.
// Assumes the handed-over register map; the port C load is a model.
`timescale 1ns/1ps
module test_quad_pwm_with_pin_takeover;
  logic core_clk = 1'h0;
  logic reset = 1'h1;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, ext_val = 8'ha5;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [7:0] pin_i, pin_o, pin_oe;
  int errors = 0;
  int n_checks = 0;
  qp_pwm_top DUT (.core_clk(core_clk), .reset(reset), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .port_c_lines_i(pin_i),
    .port_c_lines_o(pin_o), .port_c_lines_oe(pin_oe));
  qp_load u_load (.lines_o(pin_o), .lines_oe(pin_oe), .ext_val(ext_val), .lines_i(pin_i));
  initial forever #5 core_clk = ~core_clk;
  task automatic tally_and_finish;
    $display("Checks %0d, errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic hang;
    errors++;
    tally_and_finish();
  endtask
  // Each bus task starts one edge on, so a release and a new raise never share a step
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    for (int n = 0; n < 40; n++) begin
      @(posedge core_clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
      if (s_axi_bvalid === 1'h1) begin
        s_axi_bready <= 1'h0;
        chk(32'(s_axi_bresp), 32'(e));
        return;
      end
    end
    hang();
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] e);
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    for (int n = 0; n < 40; n++) begin
      @(posedge core_clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
      if (s_axi_rvalid === 1'h1) begin
        s_axi_rready <= 1'h0;
        chk(32'(s_axi_rresp), 32'(e));
        if (e == 2'h0) chk(s_axi_rdata, ed);
        return;
      end
    end
    hang();
  endtask
  task automatic cnt_hi(input int b, input int e);
    int c;
    c = 0;
    repeat (100) begin
      @(negedge core_clk);
      if (pin_o[b] === 1'h1) c++;
    end
    chk(32'(c), 32'(e));
  endtask
  task automatic t_reset;
    chk(32'(pin_oe), 32'h0);
    rd(qp_pkg::CTRL_OFS, 32'h0, 2'h0);
    rd(qp_pkg::DIR_OFS, 32'h0, 2'h0);
    for (int ch = 0; ch < 4; ch++) begin
      rd(qp_pkg::CH_BASE + 8'(ch * 8), 32'h3, 2'h0);
      rd(qp_pkg::CH_BASE + 8'(ch * 8) + qp_pkg::DUTY_SUB, 32'h0, 2'h0);
      rd(qp_pkg::CNT_BASE + 8'(ch * 4), 32'h0, 2'h0);
    end
  endtask
  // Reset while a channel owns its line and every line is an output
  task automatic t_mid_reset;
    wr(qp_pkg::DIR_OFS, 32'hff, 2'h0);
    wr(qp_pkg::CTRL_OFS, 32'h22, 2'h0);
    repeat (5) @(posedge core_clk);
    chk(32'(pin_oe), 32'hff);
    reset <= 1'h1;
    repeat (3) @(posedge core_clk);
    reset <= 1'h0;
    t_reset();
  endtask
  task automatic t_bus;
    rd(8'h80, 32'h0, 2'h3);
    wr(8'h05, 32'hff, 2'h3);
    rd(qp_pkg::DIR_OFS, 32'h0, 2'h0);
    wr(8'h28, 32'hffffffff, 2'h0);
    rd(8'h28, 32'h00ffffff, 2'h0);
  endtask
  task automatic t_gpio;
    wr(qp_pkg::DIR_OFS, 32'h5a, 2'h0);
    wr(qp_pkg::OUT_OFS, 32'h0f, 2'h0);
    chk(32'(pin_oe), 32'h5a);
    repeat (5) @(posedge core_clk);
    // Driven lines show OUT, the rest show the load
    rd(qp_pkg::IN_OFS, 32'haf, 2'h0);
    wr(qp_pkg::DIR_OFS, 32'h0, 2'h0);
  endtask
  task automatic t_pwm(input int ch, input int p, input int d, input int pol, input int e);
    wr(qp_pkg::CH_BASE + 8'(ch * 8), 32'(p), 2'h0);
    wr(qp_pkg::CH_BASE + 8'(ch * 8) + qp_pkg::DUTY_SUB, 32'(d), 2'h0);
    wr(qp_pkg::CTRL_OFS, (32'h11 << ch) | (32'(pol) << (8 + ch)), 2'h0);
    repeat (20) @(posedge core_clk);
    chk(32'(pin_oe), 32'h10 << ch);
    cnt_hi(4 + ch, e);
    wr(qp_pkg::CTRL_OFS, 32'h0, 2'h0);
    repeat (3) @(posedge core_clk);
    chk(32'(pin_oe), 32'h0);
    chk(32'(pin_o), 32'h0f);
    rd(qp_pkg::STAT_OFS, 32'h0, 2'h0);
  endtask
  // Period 10 with duty 3 rewritten to 6 while running
  task automatic t_duty;
    int len;
    int bad;
    wr(8'h20, 32'd9, 2'h0);
    wr(8'h24, 32'd3, 2'h0);
    wr(qp_pkg::CTRL_OFS, 32'h111, 2'h0);
    repeat (20) @(posedge core_clk);
    wr(8'h24, 32'd6, 2'h0);
    len = -64;
    bad = 0;
    repeat (60) begin
      @(negedge core_clk);
      if (pin_o[4] === 1'h1) len++;
      else begin
        if (len > 0 && len != 3 && len != 6) bad++;
        len = 0;
      end
    end
    chk(32'(bad), 32'h0);
    cnt_hi(4, 60);
    wr(qp_pkg::CTRL_OFS, 32'h0, 2'h0);
  endtask
  initial begin
    repeat (3) @(posedge core_clk);
    reset <= 1'h0;
    t_reset();
    t_bus();
    t_gpio();
    t_pwm(0, 9, 3, 1, 30);
    t_pwm(1, 9, 3, 0, 70);
    t_pwm(2, 1, 2, 1, 50);
    t_pwm(3, 9, 0, 1, 0);
    t_pwm(0, 4, 7, 1, 100);
    t_duty();
    t_mid_reset();
    tally_and_finish();
  end
endmodule // test_quad_pwm_with_pin_takeover
bind qp_pwm_top qp_pwm_sva u_sva (.core_clk(core_clk), .reset(reset),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .port_c_lines_oe(port_c_lines_oe));
